// File: hdl/capture_reload_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Roll-over outside baud mode sets overflow flag until software clears
// - Source select picks clock or event input
// - Roll-over rate can clock serial ports
// - Capture mode trigger fall copies count
// - Capture trigger fall sets edge flag
// - Reload mode up-count roll-over loads reload value
// - Up-only reload mode trigger fall reloads, sets flag
// - Up-only counts to FFFF then reloads
// - Up/down: pin high up, low down
// - Counting up overflows at FFFF, reloads
// - Counting down compares count to reload
// - Interrupt on enabled overflow or edge flag
// - Down at reload value loads all ones
// - Up/down mode toggles edge flag silently
// - Mode from run, baud, capture selects
module capture_reload_timer (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic ext_trigger_pin_in,
	input wire logic event_count_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic irq_out,
	output logic tx_clock_port0_out,
	output logic rx_clock_port0_out,
	output logic tx_clock_port1_out,
	output logic rx_clock_port1_out
);
	timer_b_if tif ();

	logic take;
	logic pend_q;
	logic pend_wr_q;
	logic [timer_b_pkg::ADDR_W-1:0] pend_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic wr_en;
	logic rd_en;
	logic [31:0] rd_word;
	logic [7:0] timer_b_control_q;
	logic [7:0] timer_b_mode_q;
	logic [timer_b_pkg::COUNT_W-1:0] reload_q;
	logic [timer_b_pkg::STS_W-1:0] sts_q;
	logic [timer_b_pkg::STS_W-1:0] mask_q;
	logic sts_rd;
	logic irq_q;
	logic tx0_q;
	logic rx0_q;
	logic tx1_q;
	logic rx1_q;
	logic ctl_wr;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);

	timer_b_core core_u (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.ext_trigger_pin_in(ext_trigger_pin_in),
		.event_count_in(event_count_in),
		.tif(tif.core)
	);

	// Bus address phase, one wait state in data phase
	assign take = hsel_in && htrans_in[1] && hready_in && hreadyout_q;
	assign wr_en = pend_q && pend_wr_q;
	assign rd_en = pend_q && !pend_wr_q;
	assign ctl_wr = wr_en && (pend_addr_q == timer_b_pkg::ADDR_CONTROL);
	assign sts_rd = rd_en && (pend_addr_q == timer_b_pkg::ADDR_STATUS);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pend_q <= 1'b0;
			pend_wr_q <= 1'b0;
			pend_addr_q <= '0;
			hreadyout_q <= 1'b1;
		end else begin
			pend_q <= take;
			hreadyout_q <= !take;
			if (take) begin
				pend_wr_q <= hwrite_in;
				pend_addr_q <= haddr_in[timer_b_pkg::ADDR_W-1:0];
			end
		end
	end

	always_comb begin
		rd_word = timer_b_pkg::WORD_ZERO;
		case (pend_addr_q)
			timer_b_pkg::ADDR_CONTROL: begin
				rd_word[7:0] = timer_b_control_q;
			end
			timer_b_pkg::ADDR_MODE: begin
				rd_word[7:0] = timer_b_mode_q;
			end
			timer_b_pkg::ADDR_COUNT: begin
				rd_word[timer_b_pkg::COUNT_W-1:0] = tif.count;
			end
			timer_b_pkg::ADDR_RELOAD: begin
				rd_word[timer_b_pkg::COUNT_W-1:0] = reload_q;
			end
			timer_b_pkg::ADDR_CAPTURE: begin
				rd_word[timer_b_pkg::COUNT_W-1:0] = tif.capture;
			end
			timer_b_pkg::ADDR_STATUS: begin
				rd_word[timer_b_pkg::STS_W-1:0] = sts_q;
			end
			timer_b_pkg::ADDR_MASK: begin
				rd_word[timer_b_pkg::STS_W-1:0] = mask_q;
			end
			default: begin
				rd_word = timer_b_pkg::WORD_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			hrdata_q <= timer_b_pkg::WORD_ZERO;
		end else if (rd_en) begin
			hrdata_q <= rd_word;
		end
	end

	// Control register; hardware set wins over software clear
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			timer_b_control_q <= timer_b_pkg::CONTROL_RESET;
		end else begin
			if (ctl_wr) begin
				timer_b_control_q[timer_b_pkg::CTL_CFG_MSB:0] <=
					hwdata_in[timer_b_pkg::CTL_CFG_MSB:0];
			end
			timer_b_control_q[timer_b_pkg::CTL_OVF] <= (ctl_wr ?
				hwdata_in[timer_b_pkg::CTL_OVF] :
				timer_b_control_q[timer_b_pkg::CTL_OVF]) | tif.ovf_evt;
			timer_b_control_q[timer_b_pkg::CTL_EXF] <= ((ctl_wr ?
				hwdata_in[timer_b_pkg::CTL_EXF] :
				timer_b_control_q[timer_b_pkg::CTL_EXF]) ^
				tif.exf_toggle_evt) | tif.exf_set_evt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			timer_b_mode_q <= timer_b_pkg::MODE_RESET;
		end else if (wr_en && (pend_addr_q == timer_b_pkg::ADDR_MODE)) begin
			timer_b_mode_q <= hwdata_in[7:0] & timer_b_pkg::MODE_WMASK;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			reload_q <= timer_b_pkg::COUNT_RESET;
		end else if (wr_en && (pend_addr_q == timer_b_pkg::ADDR_RELOAD)) begin
			reload_q <= hwdata_in[timer_b_pkg::COUNT_W-1:0];
		end
	end

	// Controls toward the counter core
	assign tif.run = timer_b_control_q[timer_b_pkg::CTL_RUN];
	assign tif.count_src = timer_b_control_q[timer_b_pkg::CTL_SRC];
	assign tif.cap_sel = timer_b_control_q[timer_b_pkg::CTL_CAP];
	assign tif.ext_en = timer_b_control_q[timer_b_pkg::CTL_EXT_EN];
	assign tif.down_count_enable = timer_b_mode_q[timer_b_pkg::MOD_DOWN_COUNT_ENABLE];
	assign tif.baud_sel = timer_b_control_q[timer_b_pkg::CTL_RX0] |
		timer_b_control_q[timer_b_pkg::CTL_TX0] |
		timer_b_mode_q[timer_b_pkg::MOD_RX1] |
		timer_b_mode_q[timer_b_pkg::MOD_TX1];
	assign tif.reload = reload_q;
	assign tif.cnt_wr = wr_en && (pend_addr_q == timer_b_pkg::ADDR_COUNT);
	assign tif.cnt_wdata = hwdata_in[timer_b_pkg::COUNT_W-1:0];

	// Sticky status, cleared by reading it; events win
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			sts_q <= '0;
		end else begin
			sts_q[timer_b_pkg::STS_OVF] <= (!sts_rd &&
				sts_q[timer_b_pkg::STS_OVF]) || tif.ovf_evt;
			sts_q[timer_b_pkg::STS_EXF] <= (!sts_rd &&
				sts_q[timer_b_pkg::STS_EXF]) || tif.exf_set_evt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mask_q <= '0;
		end else if (wr_en && (pend_addr_q == timer_b_pkg::ADDR_MASK)) begin
			mask_q <= hwdata_in[timer_b_pkg::STS_W-1:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_q & mask_q);
		end
	end

	// Serial port clocks from roll-over rate
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			tx0_q <= 1'b0;
			rx0_q <= 1'b0;
			tx1_q <= 1'b0;
			rx1_q <= 1'b0;
		end else begin
			tx0_q <= tif.baud_tick &&
				timer_b_control_q[timer_b_pkg::CTL_TX0];
			rx0_q <= tif.baud_tick &&
				timer_b_control_q[timer_b_pkg::CTL_RX0];
			tx1_q <= tif.baud_tick && timer_b_mode_q[timer_b_pkg::MOD_TX1];
			rx1_q <= tif.baud_tick && timer_b_mode_q[timer_b_pkg::MOD_RX1];
		end
	end

	assign hrdata_out = hrdata_q;
	assign hreadyout_out = hreadyout_q;
	assign hresp_out = 1'b0;
	assign irq_out = irq_q;
	assign tx_clock_port0_out = tx0_q;
	assign rx_clock_port0_out = rx0_q;
	assign tx_clock_port1_out = tx1_q;
	assign rx_clock_port1_out = rx1_q;

	// Checks
	sequence addr_taken_s;
		hsel_in && htrans_in[1] && hready_in && hreadyout_q;
	endsequence

	sequence one_wait_s;
		!hreadyout_q ##1 hreadyout_q;
	endsequence

	bus_wait_a: assert property (addr_taken_s |=> one_wait_s)
		else $error("data phase not one wait state");

	ovf_flag_a: assert property (
		tif.ovf_evt |=> timer_b_control_q[timer_b_pkg::CTL_OVF])
		else $error("overflow did not set flag");

	flag_sticky_a: assert property (
		timer_b_control_q[timer_b_pkg::CTL_OVF] && !ctl_wr
		|=> timer_b_control_q[timer_b_pkg::CTL_OVF])
		else $error("overflow flag dropped without write");

	count_hold_a: assert property (
		!tif.run && !tif.cnt_wr && !tif.exf_set_evt
		|=> $stable(tif.count))
		else $error("counter moved while stopped");

	capture_copy_a: assert property (
		tif.cap_evt |=> tif.capture == $past(tif.count))
		else $error("capture value wrong");

	edge_flag_a: assert property (
		tif.exf_set_evt |=> timer_b_control_q[timer_b_pkg::CTL_EXF])
		else $error("edge flag not set");

	reload_up_a: assert property (
		tif.ovf_evt && !tif.cnt_wr && (tif.mode == timer_b_pkg::MODE_RELOAD)
		&& (tif.count == timer_b_pkg::COUNT_MAX)
		|=> tif.count == $past(reload_q))
		else $error("overflow did not reload");

	underflow_a: assert property (
		tif.exf_toggle_evt && !tif.cnt_wr &&
		(tif.count != timer_b_pkg::COUNT_MAX)
		|=> tif.count == timer_b_pkg::COUNT_MAX)
		else $error("underflow did not load all ones");

	toggle_a: assert property (
		tif.exf_toggle_evt && !ctl_wr
		|=> timer_b_control_q[timer_b_pkg::CTL_EXF] !=
		$past(timer_b_control_q[timer_b_pkg::CTL_EXF]) &&
		!$rose(sts_q[timer_b_pkg::STS_EXF]))
		else $error("edge flag toggle wrong");

	baud_quiet_a: assert property (
		tif.baud_tick |-> !tif.ovf_evt ##1
		$stable(timer_b_control_q[timer_b_pkg::CTL_OVF]) || $past(ctl_wr))
		else $error("baud roll-over set overflow flag");

	irq_rise_a: assert property (
		$rose(|(sts_q & mask_q)) |=> irq_q)
		else $error("interrupt not raised");
endmodule : capture_reload_timer
`default_nettype wire

// File: hdl/timer_b_pkg.sv
package timer_b_pkg;

	localparam int COUNT_W = 16;
	localparam int ADDR_W = 12;
	localparam int STS_W = 2;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h418;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 12'h41C;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 12'h420;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 12'h424;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 12'h428;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h42C;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h430;

	// Control register fields
	localparam int CTL_OVF = 7;
	localparam int CTL_EXF = 6;
	localparam int CTL_RX0 = 5;
	localparam int CTL_TX0 = 4;
	localparam int CTL_EXT_EN = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_SRC = 1;
	localparam int CTL_CAP = 0;
	localparam int CTL_CFG_MSB = 5;

	// Mode register fields
	localparam int MOD_RX1 = 5;
	localparam int MOD_TX1 = 4;
	localparam int MOD_CLKOUT = 1;
	localparam int MOD_DOWN_COUNT_ENABLE = 0;
	localparam logic [7:0] MODE_WMASK = 8'h33;

	// Status and mask fields
	localparam int STS_OVF = 0;
	localparam int STS_EXF = 1;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_BAUD,
		MODE_CAPTURE,
		MODE_RELOAD
	} timer_mode_e;

endpackage : timer_b_pkg

// File: hdl/timer_b_if.sv
`timescale 1ns/100ps
`default_nettype none
interface timer_b_if;
	logic run;
	logic count_src;
	logic cap_sel;
	logic ext_en;
	logic down_count_enable;
	logic baud_sel;
	logic [timer_b_pkg::COUNT_W-1:0] reload;
	logic cnt_wr;
	logic [timer_b_pkg::COUNT_W-1:0] cnt_wdata;
	logic [timer_b_pkg::COUNT_W-1:0] count;
	logic [timer_b_pkg::COUNT_W-1:0] capture;
	timer_b_pkg::timer_mode_e mode;
	logic ovf_evt;
	logic exf_set_evt;
	logic exf_toggle_evt;
	logic baud_tick;
	logic cap_evt;

	modport regs (
		output run, count_src, cap_sel, ext_en, down_count_enable, baud_sel, reload,
		output cnt_wr, cnt_wdata,
		input count, capture, mode, ovf_evt, exf_set_evt, exf_toggle_evt,
		input baud_tick, cap_evt
	);
	modport core (
		input run, count_src, cap_sel, ext_en, down_count_enable, baud_sel, reload,
		input cnt_wr, cnt_wdata,
		output count, capture, mode, ovf_evt, exf_set_evt, exf_toggle_evt,
		output baud_tick, cap_evt
	);
endinterface : timer_b_if
`default_nettype wire

// File: hdl/timer_b_core.sv
`timescale 1ns/100ps
`default_nettype none
module timer_b_core (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic ext_trigger_pin_in,
	input wire logic event_count_in,
	timer_b_if.core tif
);
	logic trig_prev_q;
	logic event_prev_q;
	logic [timer_b_pkg::COUNT_W-1:0] count_q;
	logic [timer_b_pkg::COUNT_W-1:0] capture_q;
	timer_b_pkg::timer_mode_e mode;
	logic tick;
	logic trig_fall;
	logic count_down;
	logic at_top;
	logic at_floor;
	logic ext_hit;
	logic roll;

	always_comb begin
		if (!tif.run) begin
			mode = timer_b_pkg::MODE_OFF;
		end else if (tif.baud_sel) begin
			mode = timer_b_pkg::MODE_BAUD;
		end else if (tif.cap_sel) begin
			mode = timer_b_pkg::MODE_CAPTURE;
		end else begin
			mode = timer_b_pkg::MODE_RELOAD;
		end
	end

	assign tick = tif.count_src ? (event_prev_q && !event_count_in) : 1'b1;
	assign trig_fall = trig_prev_q && !ext_trigger_pin_in;
	assign count_down = (mode == timer_b_pkg::MODE_RELOAD) && tif.down_count_enable &&
		!ext_trigger_pin_in;
	assign at_top = count_q == timer_b_pkg::COUNT_MAX;
	assign at_floor = count_q == tif.reload;
	assign ext_hit = tif.ext_en && trig_fall &&
		((mode == timer_b_pkg::MODE_CAPTURE) ||
		((mode == timer_b_pkg::MODE_RELOAD) && !tif.down_count_enable));
	assign roll = tick && (mode != timer_b_pkg::MODE_OFF) &&
		(count_down ? at_floor : at_top);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			trig_prev_q <= 1'b0;
			event_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= ext_trigger_pin_in;
			event_prev_q <= event_count_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			count_q <= timer_b_pkg::COUNT_RESET;
		end else if (tif.cnt_wr) begin
			count_q <= tif.cnt_wdata;
		end else if (ext_hit && (mode == timer_b_pkg::MODE_RELOAD)) begin
			count_q <= tif.reload;
		end else if (tick && (mode != timer_b_pkg::MODE_OFF)) begin
			if (count_down) begin
				count_q <= at_floor ? timer_b_pkg::COUNT_MAX :
					count_q - timer_b_pkg::COUNT_ONE;
			end else if (at_top && (mode != timer_b_pkg::MODE_CAPTURE)) begin
				count_q <= tif.reload;
			end else begin
				count_q <= count_q + timer_b_pkg::COUNT_ONE;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			capture_q <= timer_b_pkg::COUNT_RESET;
		end else if (ext_hit && (mode == timer_b_pkg::MODE_CAPTURE)) begin
			capture_q <= count_q;
		end
	end

	assign tif.count = count_q;
	assign tif.capture = capture_q;
	assign tif.mode = mode;
	assign tif.ovf_evt = roll && (mode != timer_b_pkg::MODE_BAUD);
	assign tif.baud_tick = roll && (mode == timer_b_pkg::MODE_BAUD);
	assign tif.exf_set_evt = ext_hit;
	assign tif.exf_toggle_evt = roll && (mode == timer_b_pkg::MODE_RELOAD) &&
		tif.down_count_enable;
	assign tif.cap_evt = ext_hit && (mode == timer_b_pkg::MODE_CAPTURE);
endmodule : timer_b_core
`default_nettype wire

// File: verif/far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
	input wire logic clock_in,
	input wire logic tx0_in,
	input wire logic rx0_in,
	input wire logic tx1_in,
	input wire logic rx1_in,
	output logic trigger_out,
	output logic event_out
);
	int n_tx0 = 0;
	int n_rx0 = 0;
	int n_tx1 = 0;
	int n_rx1 = 0;

	initial begin
		trigger_out = 1'b1;
		event_out = 1'b0;
	end

	// Serial port side counts clock pulses
	always @(posedge clock_in) begin
		if (tx0_in === 1'b1) n_tx0++;
		if (rx0_in === 1'b1) n_rx0++;
		if (tx1_in === 1'b1) n_tx1++;
		if (rx1_in === 1'b1) n_rx1++;
	end

	task automatic set_trigger(input logic v);
		@(posedge clock_in);
		trigger_out <= v;
		repeat (3) @(posedge clock_in);
	endtask : set_trigger

	// Each pulse gives one falling edge on the event line
	task automatic pulse_events(input int n);
		repeat (n) begin
			@(posedge clock_in);
			event_out <= 1'b1;
			repeat (2) @(posedge clock_in);
			event_out <= 1'b0;
			repeat (2) @(posedge clock_in);
		end
	endtask : pulse_events
endmodule : far_side_model
`default_nettype wire

// File: verif/test_capture_reload_timer.sv
`timescale 1ns/100ps
`default_nettype none
module test_capture_reload_timer;
	logic clock_in = 1'b0;
	logic sys_rst_in;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic irq;
	logic trig;
	logic evt;
	logic tx0, rx0, tx1, rx1;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	always #5 clock_in = ~clock_in;

	capture_reload_timer DUT (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
		.ext_trigger_pin_in(trig), .event_count_in(evt),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.irq_out(irq), .tx_clock_port0_out(tx0), .rx_clock_port0_out(rx0),
		.tx_clock_port1_out(tx1), .rx_clock_port1_out(rx1)
	);

	far_side_model u_far (
		.clock_in(clock_in), .tx0_in(tx0), .rx0_in(rx0), .tx1_in(tx1),
		.rx1_in(rx1), .trigger_out(trig), .event_out(evt)
	);

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic xfer(input logic [11:0] a, input logic wr,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_in);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clock_in); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock_in); while (hready !== 1'b1);
		q = hrdata;
		hsel <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(a, 1'b0, 32'h0000_0000, q);
		check(q, exp);
	endtask : rd_chk

	task automatic irq_chk(input logic exp);
		repeat (3) @(posedge clock_in);
		check({30'h000_0000, hresp, irq}, {30'h000_0000, 1'b0, exp});
	endtask : irq_chk

	initial begin
		sys_rst_in <= 1'b1;
		hsel <= 1'b0;
		haddr <= 32'h0000_0000;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'b010;
		hwdata <= 32'h0000_0000;
		repeat (8) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_MODE, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0000);
		wr(12'h500, 32'h0000_00FF);
		rd_chk(12'h500, 32'h0000_0000);
		// Stopped counter holds
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_1234);
		repeat (10) @(posedge clock_in);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_1234);
		// Capture on trigger fall, event counting
		wr(timer_b_pkg::ADDR_MASK, 32'h0000_0003);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_000F);
		u_far.set_trigger(1'b0);
		rd_chk(timer_b_pkg::ADDR_CAPTURE, 32'h0000_1234);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_004F);
		irq_chk(1'b1);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0002);
		irq_chk(1'b0);
		u_far.set_trigger(1'b1);
		u_far.pulse_events(3);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_1237);
		// Reload on trigger fall
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_0005);
		wr(timer_b_pkg::ADDR_RELOAD, 32'h0000_ABCD);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_000E);
		u_far.set_trigger(1'b0);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_ABCD);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_004E);
		u_far.set_trigger(1'b1);
		// Up-only roll-over reloads
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0002);
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_FFFE);
		wr(timer_b_pkg::ADDR_RELOAD, 32'h0000_0100);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0006);
		u_far.pulse_events(2);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0100);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_0086);
		irq_chk(1'b1);
		wr(timer_b_pkg::ADDR_MASK, 32'h0000_0000);
		irq_chk(1'b0);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0001);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_0086);
		// Up/down counting
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_MODE, 32'h0000_0001);
		u_far.set_trigger(1'b0);
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_0011);
		wr(timer_b_pkg::ADDR_RELOAD, 32'h0000_0010);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0006);
		u_far.pulse_events(1);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0010);
		u_far.pulse_events(1);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_FFFF);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_00C6);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0001);
		u_far.set_trigger(1'b1);
		u_far.pulse_events(1);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0010);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_0086);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0001);
		// Baud mode clocks the serial ports
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_MODE, 32'h0000_0020);
		rd_chk(timer_b_pkg::ADDR_MODE, 32'h0000_0020);
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_FFFF);
		wr(timer_b_pkg::ADDR_RELOAD, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0016);
		u_far.pulse_events(1);
		rd_chk(timer_b_pkg::ADDR_CONTROL, 32'h0000_0016);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0000);
		check(u_far.n_tx0, 32'h0000_0001);
		check(u_far.n_rx1, 32'h0000_0001);
		check(u_far.n_rx0 + u_far.n_tx1, 32'h0000_0000);
		// Timer source steps every clock, capture mode wraps
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_MODE, 32'h0000_0000);
		wr(timer_b_pkg::ADDR_COUNT, 32'h0000_FFFE);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0005);
		wr(timer_b_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(timer_b_pkg::ADDR_COUNT, 32'h0000_0002);
		rd_chk(timer_b_pkg::ADDR_STATUS, 32'h0000_0001);
		conclude();
	end
endmodule : test_capture_reload_timer
`default_nettype wire
